// ==== include/dmc_pkg.sv ====
// Constants and types of the multiplexed DRAM cycle controller
// What this block does
// - Cell address goes out as row half then column half; chip select with row half, held through column.
// - Read cycles keep write enable high while column strobe is low.
// - Early write: data held valid around the column strobe falling edge.
// - Delayed write: data held valid around the write enable falling edge.
// - Read-modify-write lowers write enable only after column access time, strobes low.
package dmc_pkg;

   localparam int CLK_PERIOD_NS         = 40;
   // Device timing, plain defaults; adjust to the fitted part
   localparam int ROW_ADDRESS_HOLD_NS   = 20;
   localparam int COLUMN_ACCESS_TIME_NS = 165;
   localparam int RAS_ACTIVE_NS         = 250;
   localparam int WE_PULSE_NS           = 45;
   localparam int PRECHARGE_NS          = 100;

   // Least times round up to whole cycles
   localparam logic [3:0] ROW_HOLD_CYC   = 4'((ROW_ADDRESS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] CAC_CYC        = 4'((COLUMN_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] RAS_ACTIVE_CYC = 4'((RAS_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] WE_PULSE_CYC   = 4'((WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] PRECHARGE_CYC  = 4'((PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] DELAYED_WE_CYC = 4'h1;

   // Field split of the 12-bit cell address
   localparam int ROW_LSB = 0;
   localparam int COL_LSB = 6;

   typedef enum logic [2:0] {
      KIND_READ          = 3'h0,
      KIND_EARLY_WRITE   = 3'h1,
      KIND_DELAYED_WRITE = 3'h2,
      KIND_RMW           = 3'h3,
      KIND_REFRESH       = 3'h4
   } dmc_kind_type;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_ROW    = 3'h1,
      ST_HOLD   = 3'h2,
      ST_COL    = 3'h3,
      ST_ACCESS = 3'h4,
      ST_WRITE  = 3'h5,
      ST_PRE    = 3'h6
   } dmc_fsm_type;

   typedef struct packed {
      dmc_kind_type kind;
      logic [11:0]  addr;
      logic         select;
      logic         wdata;
   } dmc_cmd_type;

   typedef struct packed {
      logic       ras_n;
      logic       cas_n;
      logic       we_n;
      logic       cs_n;
      logic [5:0] addr;
      logic       din;
   } dmc_pins_type;

   typedef struct packed {
      dmc_fsm_type  fsm;
      logic [3:0]   cnt;
      logic [3:0]   cas_age;
      dmc_kind_type kind;
      logic [5:0]   col;
      logic         sel;
      logic         ready;
      logic         rd_valid;
      logic         rd_data;
      dmc_pins_type pins;
   } dmc_state_type;

   localparam dmc_pins_type PINS_IDLE = '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cs_n: 1'b1,
                                          addr: 6'h00, din: 1'b0};

   localparam dmc_state_type STATE_RESET = '{fsm: ST_IDLE, cnt: 4'h0, cas_age: 4'h0,
                                             kind: KIND_READ, col: 6'h00, sel: 1'b0,
                                             ready: 1'b0, rd_valid: 1'b0, rd_data: 1'b0,
                                             pins: PINS_IDLE};

endpackage

// ==== verilog/dmc_ctrl.sv ====
// Host-side cycle controller driving a multiplexed-address 4096 x 1 dynamic RAM
`timescale 1ns/100ps
`default_nettype none

module dmc_ctrl (
   // Clock and reset
   input  wire logic                  CORE_CLK,
   input  wire logic                  RESET_N,
   // Command port
   input  wire logic                  CMD_VALID,
   input  wire dmc_pkg::dmc_cmd_type  CMD,
   output logic                       CMD_READY,
   output logic                       RD_VALID,
   output logic                       RD_DATA,
   // Memory pins
   output dmc_pkg::dmc_pins_type      PINS,
   input  wire logic                  DRAM_DOUT
);

   dmc_pkg::dmc_state_type s_reg;
   dmc_pkg::dmc_state_type s_next;

   always_comb begin
      s_next          = s_reg;
      s_next.rd_valid = 1'b0;
      // Age of the open column strobe, saturating
      if (s_reg.pins.cas_n) begin
         s_next.cas_age = 4'h0;
      end else if (s_reg.cas_age != 4'hf) begin
         s_next.cas_age = s_reg.cas_age + 4'h1;
      end
      case (s_reg.fsm)
         dmc_pkg::ST_IDLE: begin
            s_next.ready = 1'b1;
            if (CMD_VALID && s_reg.ready) begin
               s_next.ready     = 1'b0;
               s_next.kind      = CMD.kind;
               s_next.sel       = CMD.select;
               s_next.col       = CMD.addr[dmc_pkg::COL_LSB +: 6];
               // Row half goes out first, one cycle ahead of the row strobe
               s_next.pins.addr = CMD.addr[dmc_pkg::ROW_LSB +: 6];
               // Data is held for the whole cycle so either capture edge sees it
               s_next.pins.din  = CMD.wdata;
               s_next.pins.we_n = (CMD.kind != dmc_pkg::KIND_EARLY_WRITE);
               s_next.pins.cs_n = ~CMD.select;
               s_next.fsm       = dmc_pkg::ST_ROW;
            end
         end
         dmc_pkg::ST_ROW: begin
            s_next.pins.ras_n = 1'b0;
            s_next.cnt        = (s_reg.kind == dmc_pkg::KIND_REFRESH) ?
                                dmc_pkg::RAS_ACTIVE_CYC : dmc_pkg::ROW_HOLD_CYC;
            s_next.fsm        = dmc_pkg::ST_HOLD;
         end
         dmc_pkg::ST_HOLD: begin
            if (s_reg.cnt > 4'h1) begin
               s_next.cnt = s_reg.cnt - 4'h1;
            end else if (s_reg.kind == dmc_pkg::KIND_REFRESH) begin
               // Row-only cycle: no column strobe, device output untouched
               s_next.pins = dmc_pkg::PINS_IDLE;
               s_next.cnt  = dmc_pkg::PRECHARGE_CYC;
               s_next.fsm  = dmc_pkg::ST_PRE;
            end else begin
               // Switch to the column half only with the row strobe already low
               s_next.pins.addr = s_reg.col;
               s_next.fsm       = dmc_pkg::ST_COL;
            end
         end
         dmc_pkg::ST_COL: begin
            // Column half has had one full cycle of setup
            s_next.pins.cas_n = 1'b0;
            s_next.cnt        = (s_reg.kind == dmc_pkg::KIND_DELAYED_WRITE) ?
                                dmc_pkg::DELAYED_WE_CYC : dmc_pkg::CAC_CYC;
            s_next.fsm        = dmc_pkg::ST_ACCESS;
         end
         dmc_pkg::ST_ACCESS: begin
            if (s_reg.cnt > 4'h1) begin
               s_next.cnt = s_reg.cnt - 4'h1;
            end else begin
               if (s_reg.kind == dmc_pkg::KIND_READ || s_reg.kind == dmc_pkg::KIND_RMW) begin
                  s_next.rd_data  = DRAM_DOUT;
                  s_next.rd_valid = s_reg.sel;
               end
               if (s_reg.kind == dmc_pkg::KIND_RMW || s_reg.kind == dmc_pkg::KIND_DELAYED_WRITE) begin
                  // Write enable falls after the column strobe, both strobes still low
                  s_next.pins.we_n = 1'b0;
                  s_next.cnt       = dmc_pkg::WE_PULSE_CYC;
                  s_next.fsm       = dmc_pkg::ST_WRITE;
               end else begin
                  s_next.pins = dmc_pkg::PINS_IDLE;
                  s_next.cnt  = dmc_pkg::PRECHARGE_CYC;
                  s_next.fsm  = dmc_pkg::ST_PRE;
               end
            end
         end
         dmc_pkg::ST_WRITE: begin
            if (s_reg.cnt > 4'h1) begin
               s_next.cnt = s_reg.cnt - 4'h1;
            end else begin
               s_next.pins = dmc_pkg::PINS_IDLE;
               s_next.cnt  = dmc_pkg::PRECHARGE_CYC;
               s_next.fsm  = dmc_pkg::ST_PRE;
            end
         end
         dmc_pkg::ST_PRE: begin
            // Strobes stay high long enough for the device to precharge
            if (s_reg.cnt > 4'h1) begin
               s_next.cnt = s_reg.cnt - 4'h1;
            end else begin
               s_next.ready = 1'b1;
               s_next.fsm   = dmc_pkg::ST_IDLE;
            end
         end
         default: begin
            s_next = dmc_pkg::STATE_RESET;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s_reg <= dmc_pkg::STATE_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign CMD_READY = s_reg.ready;
   assign RD_VALID  = s_reg.rd_valid;
   assign RD_DATA   = s_reg.rd_data;
   assign PINS      = s_reg.pins;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);

   sequence s_cas_fall;
      $fell(PINS.cas_n);
   endsequence

   sequence s_early_cas;
      $fell(PINS.cas_n) && !PINS.we_n;
   endsequence

   sequence s_late_we;
      $fell(PINS.we_n) && !PINS.cas_n && !$past(PINS.cas_n);
   endsequence

   sequence s_din_held;
      $stable(PINS.din) ##1 $stable(PINS.din);
   endsequence

   AST_COL_HALF_AT_CAS: assert property (s_cas_fall |-> !PINS.ras_n && PINS.addr == s_reg.col)
      else $error("Column half not on the address pins at column strobe");
   AST_CS_AT_CAS: assert property (s_cas_fall |-> PINS.cs_n == !s_reg.sel)
      else $error("Chip select not valid at column strobe");
   // Row half unchanged in the cycle the row strobe falls, with the column strobe still high one cycle later
   AST_ROW_HOLD: assert property ($fell(PINS.ras_n) |-> $stable(PINS.addr) ##1 PINS.cas_n)
      else $error("Row half changed right after row strobe fell");
   AST_ADDR_SWITCH: assert property ($changed(PINS.addr) && !PINS.ras_n |-> PINS.cas_n && !$past(PINS.ras_n))
      else $error("Address switched before row strobe fell or after column strobe");
   AST_READ_WE_HIGH: assert property (!PINS.cas_n && !PINS.ras_n && s_reg.kind == dmc_pkg::KIND_READ |-> PINS.we_n)
      else $error("Write enable low during a read cycle");
   AST_EARLY_DIN: assert property (s_early_cas |-> s_din_held)
      else $error("Data not held around column strobe in early write");
   AST_DELAYED_DIN: assert property (s_late_we |-> s_din_held)
      else $error("Data not held around write enable in delayed write");
   AST_RMW_AFTER_CAC: assert property ($fell(PINS.we_n) && s_reg.kind == dmc_pkg::KIND_RMW
                                       |-> !PINS.cas_n && !PINS.ras_n && s_reg.cas_age >= dmc_pkg::CAC_CYC)
      else $error("Read-modify-write lowered write enable before column access time");

   // Steps of a whole memory cycle
   sequence s_ras_fall;
      $fell(PINS.ras_n);
   endsequence

   sequence s_ras_rise;
      $rose(PINS.ras_n);
   endsequence

   sequence s_col_held;
      $stable(PINS.addr) ##1 $stable(PINS.addr);
   endsequence

   // Pulse widths below follow the package defaults; retune them with the constants
   sequence s_we_pulse;
      !PINS.we_n [*2] ##1 PINS.we_n;
   endsequence

   sequence s_refresh_row;
      !PINS.ras_n [*7] ##1 PINS.ras_n;
   endsequence

   // Strobe nesting: the column strobe never stands alone, all controls close together
   AST_CAS_INSIDE_RAS: assert property (!PINS.cas_n |-> !PINS.ras_n)
      else $error("Column strobe low without the row strobe");
   AST_ROW_SETUP: assert property (s_ras_fall
                                   |-> $stable(PINS.addr) && $stable(PINS.cs_n) && $stable(PINS.din))
      else $error("Row half, select or data changed as the row strobe fell");
   AST_STROBES_RISE_TOGETHER: assert property (s_ras_rise |-> PINS.cas_n && PINS.we_n && PINS.cs_n)
      else $error("Row strobe rose while another control was still active");
   AST_COL_HOLD: assert property (s_cas_fall |-> s_col_held)
      else $error("Column half changed around the column strobe fall");
   AST_DIN_STEADY: assert property (!PINS.ras_n && !$past(PINS.ras_n)
                                    |-> $stable(PINS.din) && $stable(PINS.cs_n))
      else $error("Data or select changed inside a memory cycle");
   AST_EARLY_WE_FIRST: assert property ($fell(PINS.cas_n) && s_reg.kind == dmc_pkg::KIND_EARLY_WRITE
                                        |-> !PINS.we_n && !$past(PINS.we_n))
      else $error("Early write lowered write enable after the column strobe");
   AST_DELAYED_WE_LATE: assert property ($fell(PINS.we_n) && s_reg.kind == dmc_pkg::KIND_DELAYED_WRITE
                                         |-> !PINS.cas_n && !$past(PINS.cas_n))
      else $error("Delayed write lowered write enable before the column strobe");
   AST_WE_PULSE: assert property ($fell(PINS.we_n) && !PINS.cas_n |-> s_we_pulse)
      else $error("Write pulse inside the column strobe has the wrong width");
   AST_RD_AFTER_CAC: assert property ($rose(RD_VALID) |-> s_reg.cas_age >= dmc_pkg::CAC_CYC ##1 !RD_VALID)
      else $error("Read data taken before column access time or strobe held too long");
   AST_REFRESH_WIDTH: assert property ($fell(PINS.ras_n) && s_reg.kind == dmc_pkg::KIND_REFRESH
                                       |-> s_refresh_row)
      else $error("Row-only cycle kept the row strobe low for the wrong time");

endmodule

`default_nettype wire

// ==== bench/dmc_dram_model.sv ====
// Behavioural 4096 x 1 multiplexed-address dynamic RAM seen from its pins
`timescale 1ns/100ps
`default_nettype none

module dmc_dram_model (
   // Memory pins
   input  wire dmc_pkg::dmc_pins_type pins,
   // Data output, float shown as the inverse of the last value
   output logic                       dout
);
   logic       mem [4096];
   logic [5:0] row;
   logic [5:0] col;
   logic       sel;
   logic       oe;
   logic       q;

   initial begin
      foreach (mem[i]) mem[i] = 1'b0;
      oe = 1'b0;
      q = 1'b0;
      sel = 1'b0;
   end

   always @(negedge pins.ras_n) row = pins.addr;

   always @(negedge pins.cas_n) begin
      oe = 1'b0;
      if (!pins.ras_n) begin
         col = pins.addr;
         sel = !pins.cs_n;
         if (sel && !pins.we_n) begin
            mem[{col, row}] = pins.din;
            q = pins.din;
         end else if (sel) begin
            q = mem[{col, row}];
         end
         oe = sel;
      end
   end

   // Delayed write strobes data on the later write-enable edge
   always @(negedge pins.we_n) begin
      if (!pins.ras_n && !pins.cas_n && sel) mem[{col, row}] = pins.din;
   end

   // Row-only cycles and strobe rises never touch the output latch
   assign dout = oe ? q : ~q;
endmodule

`default_nettype wire

// ==== bench/dmc_ctrl_bench.sv ====
// Self-checking bench of the DRAM cycle controller
`timescale 1ns/100ps
`default_nettype none

module dmc_ctrl_bench;
   logic                 clk;
   logic                 rst_n;
   logic                 cmd_valid;
   dmc_pkg::dmc_cmd_type cmd;
   logic                 cmd_ready;
   logic                 rd_valid;
   logic                 rd_data;
   dmc_pkg::dmc_pins_type pins;
   logic                 dout;
   logic                 exp_mem [4096];
   logic [2:0]           cur_k;
   logic [11:0]          cur_a;
   int                   num_errors;
   int                   check_count;

   dmc_ctrl DUT (.CORE_CLK(clk), .RESET_N(rst_n), .CMD_VALID(cmd_valid), .CMD(cmd), .CMD_READY(cmd_ready),
                 .RD_VALID(rd_valid), .RD_DATA(rd_data), .PINS(pins), .DRAM_DOUT(dout));
   dmc_dram_model mem_model (.pins(pins), .dout(dout));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic give_verdict;
      $display("Checks %0d, errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   function automatic logic expect_read(input logic [2:0] k, input logic s);
      return s && (k == 3'h0 || k == 3'h3);
   endfunction

   // Cycle length from acceptance until ready again, from the package timing
   function automatic int expect_cycles(input logic [2:0] k);
      int len;
      len = 1 + int'(dmc_pkg::ROW_HOLD_CYC) + 1 + int'(dmc_pkg::PRECHARGE_CYC);
      if (k == 3'h2) len = len + int'(dmc_pkg::DELAYED_WE_CYC) + int'(dmc_pkg::WE_PULSE_CYC);
      else len = len + int'(dmc_pkg::CAC_CYC);
      if (k == 3'h3) len = len + int'(dmc_pkg::WE_PULSE_CYC);
      if (k == 3'h4) len = 1 + int'(dmc_pkg::RAS_ACTIVE_CYC) + int'(dmc_pkg::PRECHARGE_CYC);
      return len;
   endfunction

   // Pin ordering watched at each row and column strobe fall
   always @(negedge pins.ras_n) check(12'(pins.addr), 12'(cur_a[5:0]));
   always @(negedge pins.cas_n) check(12'(pins.addr), 12'(cur_a[11:6]));
   always @(negedge clk) begin
      if (cur_k == 3'h0 && pins.cas_n === 1'b0) check(12'(pins.we_n), 12'h001);
      if (cur_k == 3'h4 && rst_n) check(12'(pins.cas_n), 12'h001);
   end

   task automatic run(input logic [2:0] k, input logic [11:0] a, input logic s, input logic w);
      int   n;
      logic hit;
      logic got;
      hit = 1'b0;
      got = 1'b0;
      @(negedge clk);
      cur_k = k;
      cur_a = a;
      cmd_valid = 1'b1;
      cmd = '{kind: dmc_pkg::dmc_kind_type'(k), addr: a, select: s, wdata: w};
      n = 0;
      // Ready is registered: seen high here, the next rising edge takes the command
      while (cmd_ready !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      cmd_valid = 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         if (rd_valid === 1'b1) begin
            hit = 1'b1;
            got = rd_data;
         end
         n++;
      end while (cmd_ready !== 1'b1 && n < 50);
      check(12'(n), 12'(expect_cycles(k)));
      if (n >= 50) num_errors++;
      check(12'(hit), 12'(expect_read(k, s)));
      if (expect_read(k, s)) check(12'(got), 12'(exp_mem[a]));
      if (s && (k == 3'h1 || k == 3'h2 || k == 3'h3)) exp_mem[a] = w;
   endtask

   initial begin
      #200000;
      num_errors++;
      give_verdict();
   end

   initial begin
      logic [11:0] a;
      num_errors = 0;
      check_count = 0;
      foreach (exp_mem[i]) exp_mem[i] = 1'b0;
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd = '0;
      cur_k = 3'h7;
      cur_a = 12'h000;
      void'($urandom(57682));
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      // Boundary addresses, every kind, refresh between write and read
      run(3'h1, 12'hfff, 1'b1, 1'b1);
      run(3'h4, 12'h000, 1'b1, 1'b0);
      run(3'h0, 12'hfff, 1'b1, 1'b0);
      run(3'h2, 12'h000, 1'b1, 1'b1);
      run(3'h3, 12'h000, 1'b1, 1'b0);
      run(3'h0, 12'h000, 1'b1, 1'b0);
      run(3'h1, 12'hfff, 1'b0, 1'b0);
      run(3'h0, 12'hfff, 1'b0, 1'b0);
      run(3'h0, 12'hfff, 1'b1, 1'b0);
      // Small address pool so reads revisit written cells
      for (int i = 0; i < 60; i++) begin
         a = 12'($urandom) & 12'hc03;
         run(3'($urandom % 5), a, 1'($urandom % 4 != 0), 1'($urandom));
      end
      give_verdict();
   end
endmodule

`default_nettype wire
